// *** src/pin_wake_cfg.svh ***
`ifndef PIN_WAKE_CFG_SVH
`define PIN_WAKE_CFG_SVH
// Clock rate and the one-second tick derived from it
`define CLK_HZ       100000000
`define TICK_MS      1000
`define SEC_CYCLES   ((`CLK_HZ / 1000) * `TICK_MS)
// Receive buffer and flow threshold
`define BUF_DEPTH    1024
`define BUF_AW       10
`define RTS_SLACK    8
// Register byte offsets
`define OFS_WAKE     8'h00
`define OFS_SLEEP    8'h04
`define OFS_WAKET    8'h08
`define OFS_MATCH    8'h0c
`define OFS_FSIZE    8'h10
`define OFS_BAUD     8'h14
`define OFS_UART     8'h18
`define OFS_IOMASK   8'h1c
`define OFS_IOFUNC   8'h20
`define OFS_PRINT    8'h24
`define OFS_GPOUT    8'h28
`define OFS_PINS     8'h2c
`define OFS_STATUS   8'h30
`define OFS_NETCTL   8'h34
`define OFS_RXDATA   8'h38
`define OFS_TXDATA   8'h3c
`define OFS_OPENSTR  8'h40
`define OFS_CLOSESTR 8'h44
// Field positions
`define NET_READY    0
`define NET_ASSOC    1
`define NET_IPOK     2
`define NET_TCP      3
`define NET_CMD      4
`define MATCH_EN     8
// Factory default values, reserved pin mask and restore pulse count
`define TRIG_DEF     3'h1
`define SLEEP_DEF    16'h0000
`define WAKE_DEF     16'h000a
`define FSIZE_DEF    8'h10
`define BAUD_DEF     4'h3
`define IOMASK_DEF   10'h078
`define PIN_RSVD     10'h180
`define FACT_TOGGLES 2'h3
`endif

// *** src/pin_wake_pkg.sv ***
package pin_wake_pkg;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} rx_state_type;
	typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_type;
	typedef enum logic {PW_AWAKE = 1'b0, PW_ASLEEP = 1'b1} power_state_type;
endpackage

// *** src/rx_buffer_mem.sv ***
`timescale 1ns/1ps
`include "pin_wake_cfg.svh"
module rx_buffer_mem (
	input  wire logic                 clk,
	input  wire logic                 we,
	input  wire logic [`BUF_AW-1:0]   waddr,
	input  wire logic [7:0]           wdata,
	input  wire logic [`BUF_AW-1:0]   raddr,
	output logic      [7:0]           rdata
);
	logic [7:0] mem [0:`BUF_DEPTH-1];
	logic [7:0] rdata_r;
	// Storage array
	always_ff @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
	end
	// Write-first, so a byte stored at the head shows at once
	always_ff @(posedge clk) begin
		if (we && waddr == raddr)
			rdata_r <= wdata;
		else
			rdata_r <= mem[raddr];
	end
	assign rdata = rdata_r;
endmodule

// *** src/uart_rx_engine.sv ***
`timescale 1ns/1ps
module uart_rx_engine
	import pin_wake_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        enable,
	input  wire logic        rxd,
	input  wire logic [16:0] bitDiv,
	output logic      [7:0]  rxByte,
	output logic             rxValid
);
	rx_state_type state_r;
	logic [16:0]  divCnt_r;
	logic [2:0]   bitCnt_r;
	logic [7:0]   shift_r;
	logic [7:0]   byte_r;
	logic         valid_r;
	// 8N1 receiver; half-bit wait centres each sample in its cell
	always_ff @(posedge clk) begin
		valid_r <= 1'b0;
		if (rst || !enable) begin
			state_r <= RX_IDLE;
			divCnt_r <= '0;
			bitCnt_r <= '0;
			shift_r <= '0;
			byte_r <= '0;
		end else if (state_r != RX_IDLE && divCnt_r != 17'h0) begin
			divCnt_r <= divCnt_r - 17'h1;
		end else begin
			case (state_r)
			RX_IDLE: begin
				if (!rxd) begin
					state_r <= RX_START;
					divCnt_r <= {1'b0, bitDiv[16:1]};
				end
			end
			RX_START: begin
				divCnt_r <= bitDiv - 17'h1;
				bitCnt_r <= '0;
				// A glitch shorter than half a bit is dropped
				state_r <= rxd ? RX_IDLE : RX_DATA;
			end
			RX_DATA: begin
				divCnt_r <= bitDiv - 17'h1;
				shift_r <= {rxd, shift_r[7:1]};
				bitCnt_r <= bitCnt_r + 3'h1;
				if (bitCnt_r == 3'h7)
					state_r <= RX_STOP;
			end
			RX_STOP: begin
				// Framing errors are discarded silently
				if (rxd) begin
					byte_r <= shift_r;
					valid_r <= 1'b1;
				end
				state_r <= RX_IDLE;
			end
			default: state_r <= RX_IDLE;
			endcase
		end
	end
	assign rxByte = byte_r;
	assign rxValid = valid_r;
endmodule

// *** src/module_pin_wake_flow_ctrl.sv ***
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pin_wake_cfg.svh"
module module_pin_wake_flow_ctrl
	import pin_wake_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `SEC_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wrData,
	input  wire logic        wrEn,
	input  wire logic        rdEn,
	output logic      [31:0] rdData,
	input  wire logic [9:0]  progPinIn,
	output logic      [9:0]  progPinOut,
	output logic      [9:0]  progPinOe,
	input  wire logic [3:0]  wakeSenseIn,
	output logic             asleep,
	output logic             connReq
);
	logic [13:0]     syncA_r, syncB_r;
	logic [9:0]      pinSync;
	logic [3:0]      senseSync;
	logic [2:0]      trig_r, ioFunc_r;
	logic [15:0]     sleepT_r, wakeT_r, sleepCnt_r, wakeCnt_r;
	logic [7:0]      match_r, fwdSize_r, print_r, sinceRel_r;
	logic            matchEn_r, flow_r, factoryHit;
	logic [3:0]      baud_r;
	logic [1:0]      parity_r, strapCnt_r, factCnt_r;
	logic [9:0]      ioMask_r, gpOut_r, pinOut_r, pinOe_r;
	logic [9:0]      outNxt, oeNxt;
	logic [31:0]     openStr_r, closeStr_r, rdData_r, tickCnt_r;
	logic [4:0]      net_r;
	logic [24:0]     baudCur, baudNew;
	logic [16:0]     bitDiv, txDiv_r;
	logic            strapArm_r, pin9Prev_r, secTick_r, senseWake;
	power_state_type power_r;
	logic [7:0]      rxByte, bufData;
	logic            rxValid, push, pop, fwdRelease;
	logic [9:0]      wrPtr_r, rdPtr_r, rdPtr_nxt;
	logic [10:0]     count_r, count_nxt, fwdAvail_r;
	logic            rts_r, connReq_r;
	tx_state_type    txState_r;
	logic [9:0]      txShift_r;
	logic [3:0]      txBits_r;
	logic [7:0]      txHold_r;
	logic [31:0]     note_r;
	logic            txHoldV_r, noteV_r, tcpPrev_r;
	logic            txGo, noteGo, ctsBlock, txLine;

	// Register write decode, shared by every write path
	function automatic logic wrAt(input logic [7:0] ofs);
		wrAt = wrEn && (addr == ofs);
	endfunction

	// Baud code to {default forwarding count, clocks per bit}
	function automatic logic [24:0] baudEntry(input logic [3:0] code);
		case (code)
		4'h0: baudEntry = {8'h02, 17'(`CLK_HZ / 1200)};
		4'h1: baudEntry = {8'h04, 17'(`CLK_HZ / 2400)};
		4'h2: baudEntry = {8'h08, 17'(`CLK_HZ / 4800)};
		4'h4: baudEntry = {8'h20, 17'(`CLK_HZ / 19200)};
		4'h5: baudEntry = {8'h40, 17'(`CLK_HZ / 38400)};
		4'h6: baudEntry = {8'h60, 17'(`CLK_HZ / 57600)};
		4'h7: baudEntry = {8'hc0, 17'(`CLK_HZ / 115200)};
		4'h8: baudEntry = {8'hff, 17'(`CLK_HZ / 230400)};
		4'h9: baudEntry = {8'hff, 17'(`CLK_HZ / 460800)};
		4'ha: baudEntry = {8'hff, 17'(`CLK_HZ / 921600)};
		default: baudEntry = {8'h10, 17'(`CLK_HZ / 9600)};
		endcase
	endfunction
	assign baudCur = baudEntry(baud_r);
	assign baudNew = baudEntry(wrData[3:0]);
	assign bitDiv = baudCur[16:0];

	// two-stage synchronisers
	// Idle level of the receive, strap and wake-sense pins is high, so reset to ones
	always_ff @(posedge clk) begin
		if (rst) begin
			syncA_r <= '1;
			syncB_r <= '1;
		end else begin
			syncA_r <= {wakeSenseIn, progPinIn};
			syncB_r <= syncA_r;
		end
	end
	assign pinSync = syncB_r[9:0];
	assign senseSync = syncB_r[13:10];

	// factory defaults on reset or restore
	// Network status is live state, not configuration, so it is kept
	always_ff @(posedge clk) begin
		if (rst || factoryHit) begin
			trig_r <= `TRIG_DEF;
			sleepT_r <= `SLEEP_DEF;
			wakeT_r <= `WAKE_DEF;
			match_r <= 8'h00;
			matchEn_r <= 1'b0;
			fwdSize_r <= `FSIZE_DEF;
			baud_r <= `BAUD_DEF;
			flow_r <= 1'b0;
			parity_r <= 2'h0;
			ioMask_r <= `IOMASK_DEF;
			ioFunc_r <= 3'h0;
			print_r <= 8'h00;
			gpOut_r <= 10'h000;
			openStr_r <= 32'h0;
			closeStr_r <= 32'h0;
		end else begin
			if (wrAt(`OFS_WAKE))
				trig_r <= wrData[2:0];
			if (wrAt(`OFS_SLEEP))
				sleepT_r <= wrData[15:0];
			if (wrAt(`OFS_WAKET))
				wakeT_r <= wrData[15:0];
			if (wrAt(`OFS_MATCH)) begin
				match_r <= wrData[7:0];
				matchEn_r <= wrData[`MATCH_EN];
			end
			if (wrAt(`OFS_BAUD)) begin
				baud_r <= wrData[3:0];
				fwdSize_r <= baudNew[24:17];
			end else if (wrAt(`OFS_FSIZE)) begin
				fwdSize_r <= wrData[7:0];
			end
			if (wrAt(`OFS_UART)) begin
				flow_r <= wrData[0];
				parity_r <= wrData[2:1];
			end
			if (wrAt(`OFS_IOMASK))
				ioMask_r <= (wrData[9:0] & ~`PIN_RSVD)
					| (ioMask_r & `PIN_RSVD);
			if (wrAt(`OFS_IOFUNC))
				ioFunc_r <= wrData[2:0];
			if (wrAt(`OFS_PRINT))
				print_r <= wrData[7:0];
			if (wrAt(`OFS_GPOUT))
				gpOut_r <= wrData[9:0];
			if (wrAt(`OFS_OPENSTR))
				openStr_r <= wrData;
			if (wrAt(`OFS_CLOSESTR))
				closeStr_r <= wrData;
		end
	end

	// Network and readiness status supplied by firmware
	always_ff @(posedge clk) begin
		if (rst)
			net_r <= 5'h00;
		else if (wrAt(`OFS_NETCTL))
			net_r <= wrData[4:0];
	end

	// strap caught after reset, then rising edges counted
	always_ff @(posedge clk) begin
		if (rst) begin
			strapCnt_r <= 2'h0;
			strapArm_r <= 1'b0;
			factCnt_r <= 2'h0;
			pin9Prev_r <= 1'b1;
		end else begin
			pin9Prev_r <= pinSync[9];
			if (strapCnt_r != 2'h3)
				strapCnt_r <= strapCnt_r + 2'h1;
			if (strapCnt_r == 2'h2)
				strapArm_r <= pinSync[9];
			else if (factoryHit)
				strapArm_r <= 1'b0;
			if (strapArm_r && pinSync[9] && !pin9Prev_r)
				factCnt_r <= factCnt_r + 2'h1;
		end
	end
	assign factoryHit = strapArm_r && pinSync[9] && !pin9Prev_r
		&& factCnt_r == `FACT_TOGGLES - 2'h1;

	// One-second tick; phase is free running, so the sleep timer can run up to 1 s short
	always_ff @(posedge clk) begin
		if (rst || tickCnt_r == TICK_CYCLES - 1) begin
			tickCnt_r <= 32'h0;
			secTick_r <= !rst;
		end else begin
			tickCnt_r <= tickCnt_r + 32'h1;
			secTick_r <= 1'b0;
		end
	end

	assign senseWake = trig_r >= 3'h1 && trig_r <= 3'h4
		&& !senseSync[trig_r[1:0] - 2'h1];

	always_ff @(posedge clk) begin
		if (rst) begin
			power_r <= PW_AWAKE;
			sleepCnt_r <= `SLEEP_DEF;
			wakeCnt_r <= 16'h0;
		end else begin
			case (power_r)
			PW_AWAKE: begin
				if (rxValid || sleepCnt_r == 16'h0) begin
					sleepCnt_r <= sleepT_r;
				end else if (secTick_r && !net_r[`NET_TCP]
					&& !net_r[`NET_CMD]) begin
					sleepCnt_r <= sleepCnt_r - 16'h1;
					if (sleepCnt_r == 16'h1) begin
						power_r <= PW_ASLEEP;
						wakeCnt_r <= wakeT_r;
					end
				end
			end
			PW_ASLEEP: begin
				if (senseWake || (secTick_r && wakeCnt_r == 16'h1))
					power_r <= PW_AWAKE;
				else if (secTick_r && wakeCnt_r != 16'h0)
					wakeCnt_r <= wakeCnt_r - 16'h1;
			end
			default: power_r <= PW_AWAKE;
			endcase
		end
	end

	uart_rx_engine u_rx (
		.clk     (clk),
		.rst     (rst),
		.enable  (power_r == PW_AWAKE),
		.rxd     (pinSync[1]),
		.bitDiv  (bitDiv),
		.rxByte  (rxByte),
		.rxValid (rxValid)
	);

	// byte store addressed by ring pointers
	rx_buffer_mem u_mem (
		.clk   (clk),
		.we    (push),
		.waddr (wrPtr_r),
		.wdata (rxByte),
		.raddr (rdPtr_nxt),
		.rdata (bufData)
	);

	// A byte that arrives while full is dropped
	assign push = rxValid && count_r != 11'(`BUF_DEPTH);
	assign pop = rdEn && addr == `OFS_RXDATA && fwdAvail_r != 11'h0;
	assign fwdRelease = push && ((matchEn_r && rxByte == match_r)
		|| ({1'b0, sinceRel_r} + 9'h1 >= {1'b0, fwdSize_r}));
	assign rdPtr_nxt = rdPtr_r + {9'h0, pop};
	assign count_nxt = count_r + {10'h0, push} - {10'h0, pop};

	// Buffer bookkeeping; a release hands over everything stored
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= 10'h0;
			rdPtr_r <= 10'h0;
			count_r <= 11'h0;
			fwdAvail_r <= 11'h0;
			sinceRel_r <= 8'h0;
		end else begin
			wrPtr_r <= wrPtr_r + {9'h0, push};
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
			fwdAvail_r <= fwdRelease ? count_nxt
				: fwdAvail_r - {10'h0, pop};
			sinceRel_r <= fwdRelease ? 8'h0 : sinceRel_r + {7'h0, push};
		end
	end

	// RTS high until ready or near full
	// Slack leaves room for bytes the host has already started
	always_ff @(posedge clk) begin
		if (rst)
			rts_r <= 1'b1;
		else
			rts_r <= !net_r[`NET_READY] || (flow_r
				&& count_r >= 11'(`BUF_DEPTH - `RTS_SLACK));
	end

	// CTS high blocks a new byte
	assign ctsBlock = flow_r && pinSync[2];
	assign noteGo = noteV_r && note_r[7:0] != 8'h00;
	assign txGo = txState_r == TX_IDLE && power_r == PW_AWAKE
		&& !ctsBlock && (noteGo || txHoldV_r);

	// notification strings, low byte first, NUL ends
	always_ff @(posedge clk) begin
		if (rst) begin
			tcpPrev_r <= 1'b0;
			note_r <= 32'h0;
			noteV_r <= 1'b0;
		end else begin
			tcpPrev_r <= net_r[`NET_TCP];
			if (net_r[`NET_TCP] && !tcpPrev_r) begin
				note_r <= openStr_r;
				noteV_r <= 1'b1;
			end else if (!net_r[`NET_TCP] && tcpPrev_r) begin
				note_r <= closeStr_r;
				noteV_r <= 1'b1;
			end else if (txGo && noteGo) begin
				note_r <= {8'h00, note_r[31:8]};
			end else if (noteV_r && !noteGo) begin
				noteV_r <= 1'b0;
			end
		end
	end

	// Software byte holding register; writes while full are ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			txHold_r <= 8'h00;
			txHoldV_r <= 1'b0;
		end else if (txGo && !noteGo) begin
			txHoldV_r <= 1'b0;
		end else if (wrAt(`OFS_TXDATA) && !txHoldV_r) begin
			txHold_r <= wrData[7:0];
			txHoldV_r <= 1'b1;
		end
	end

	// 8N1 transmitter; sleeping aborts any byte in flight
	always_ff @(posedge clk) begin
		if (rst || power_r == PW_ASLEEP) begin
			txState_r <= TX_IDLE;
			txShift_r <= 10'h3ff;
			txBits_r <= 4'h0;
			txDiv_r <= 17'h0;
		end else begin
			case (txState_r)
			TX_IDLE: begin
				if (txGo) begin
					txState_r <= TX_SHIFT;
					txShift_r <= {1'b1, noteGo ? note_r[7:0] : txHold_r,
						1'b0};
					txBits_r <= 4'h0;
					txDiv_r <= bitDiv - 17'h1;
				end
			end
			TX_SHIFT: begin
				if (txDiv_r != 17'h0) begin
					txDiv_r <= txDiv_r - 17'h1;
				end else begin
					txDiv_r <= bitDiv - 17'h1;
					txShift_r <= {1'b1, txShift_r[9:1]};
					txBits_r <= txBits_r + 4'h1;
					if (txBits_r == 4'h9)
						txState_r <= TX_IDLE;
				end
			end
			default: txState_r <= TX_IDLE;
			endcase
		end
	end
	assign txLine = txState_r == TX_SHIFT ? txShift_r[0] : 1'b1;

	// mask drives GPIO, then roles override
	always_comb begin
		oeNxt = ioMask_r & ~`PIN_RSVD;
		outNxt = gpOut_r & oeNxt;
		oeNxt[0] = 1'b1;
		outNxt[0] = txLine;
		oeNxt[1] = 1'b0;
		outNxt[1] = 1'b0;
		if (flow_r) begin
			oeNxt[2] = 1'b0;
			outNxt[2] = 1'b0;
			oeNxt[3] = 1'b1;
		end
		if (oeNxt[3])
			outNxt[3] = rts_r;
		if (ioFunc_r[0]) begin
			oeNxt[4] = 1'b1;
			outNxt[4] = net_r[`NET_ASSOC] && net_r[`NET_IPOK];
		end
		if (ioFunc_r[1]) begin
			oeNxt[5] = 1'b0;
			outNxt[5] = 1'b0;
		end
		if (ioFunc_r[2]) begin
			oeNxt[6] = 1'b1;
			outNxt[6] = net_r[`NET_TCP];
		end
	end

	// Registered pin drive and connection request
	always_ff @(posedge clk) begin
		if (rst) begin
			pinOut_r <= 10'h001;
			pinOe_r <= 10'h001;
			connReq_r <= 1'b0;
		end else begin
			pinOut_r <= outNxt;
			pinOe_r <= oeNxt;
			connReq_r <= ioFunc_r[1] && pinSync[5];
		end
	end

	// Read port; data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst || !rdEn) begin
			rdData_r <= 32'h0;
		end else begin
			case (addr)
			`OFS_WAKE:     rdData_r <= {29'h0, trig_r};
			`OFS_SLEEP:    rdData_r <= {16'h0, sleepT_r};
			`OFS_WAKET:    rdData_r <= {16'h0, wakeT_r};
			`OFS_MATCH:    rdData_r <= {23'h0, matchEn_r, match_r};
			`OFS_FSIZE:    rdData_r <= {24'h0, fwdSize_r};
			`OFS_BAUD:     rdData_r <= {28'h0, baud_r};
			`OFS_UART:     rdData_r <= {29'h0, parity_r, flow_r};
			`OFS_IOMASK:   rdData_r <= {22'h0, ioMask_r};
			`OFS_IOFUNC:   rdData_r <= {29'h0, ioFunc_r};
			`OFS_PRINT:    rdData_r <= {24'h0, print_r};
			`OFS_GPOUT:    rdData_r <= {22'h0, gpOut_r};
			`OFS_PINS:     rdData_r <= {18'h0, senseSync, pinSync};
			`OFS_STATUS:   rdData_r <= {4'h0, fwdAvail_r, count_r,
				1'b0, strapArm_r, rts_r, connReq_r, txHoldV_r,
				power_r == PW_ASLEEP};
			`OFS_NETCTL:   rdData_r <= {27'h0, net_r};
			`OFS_RXDATA:   rdData_r <= {24'h0, pop ? bufData : 8'h00};
			`OFS_OPENSTR:  rdData_r <= openStr_r;
			`OFS_CLOSESTR: rdData_r <= closeStr_r;
			default:       rdData_r <= 32'h0;
			endcase
		end
	end

	assign rdData = rdData_r;
	assign progPinOut = pinOut_r;
	assign progPinOe = pinOe_r;
	assign asleep = power_r;
	assign connReq = connReq_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_rts_notready: assert property (
		!net_r[`NET_READY] |=> ##1 progPinOut[3] || !progPinOe[3])
		else $error("RTS low before system ready");
	a_cts_hold: assert property (
		txState_r == TX_IDLE && ctsBlock |=> txState_r == TX_IDLE)
		else $error("byte started while CTS high");
	a_mask_rsvd: assert property (
		ioMask_r[8:7] == 2'b00 && !progPinOe[7] && !progPinOe[8])
		else $error("reserved pins disturbed");
	a_sleep_quiet: assert property (
		power_r == PW_ASLEEP |-> txState_r == TX_IDLE && !rxValid)
		else $error("UART active during sleep");
	a_sense_wake: assert property (
		power_r == PW_ASLEEP && senseWake |=> power_r == PW_AWAKE)
		else $error("sensor low did not wake");
	a_fwd_match: assert property (
		push && matchEn_r && rxByte == match_r |=> fwdAvail_r == count_r)
		else $error("terminator did not release data");
	a_fwd_single: assert property (
		push && fwdSize_r <= 8'h01 |=> fwdAvail_r == count_r)
		else $error("count of one did not forward at once");
	a_baud_size: assert property (
		wrAt(`OFS_BAUD) |=> fwdSize_r == $past(baudNew[24:17]))
		else $error("baud write left count unchanged");
	a_alt_pin4: assert property (
		ioFunc_r[0] && net_r[`NET_ASSOC] && net_r[`NET_IPOK]
		|=> progPinOe[4] && progPinOut[4])
		else $error("pin 4 not showing network up");
	a_factory_def: assert property (
		factoryHit |=> ioMask_r == `IOMASK_DEF && print_r == 8'h00
		&& trig_r == `TRIG_DEF && !flow_r)
		else $error("factory restore incomplete");
	c_sleep_entry: cover property (power_r == PW_AWAKE ##1 asleep);
	c_factory: cover property (factoryHit);
	c_note_sent: cover property (txGo && noteGo);
	c_release: cover property (fwdRelease ##[1:20] pop);
endmodule

// *** verif/host_mcu_model.sv ***
`timescale 1ns/1ps
module host_mcu_model (
	input  wire logic clk,
	input  wire logic devTx,
	output logic      hostTx,
	output logic      cts,
	output logic      conn,
	output logic      fact
);
	int         bitCyc = 108;
	logic [7:0] rxQ[$];
	initial begin
		hostTx = 1'b1;
		cts = 1'b0;
		conn = 1'b0;
		fact = 1'b1;
	end
	// One 8N1 frame, low bit first, line idles high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			hostTx <= f[i];
			repeat (bitCyc) @(posedge clk);
		end
	endtask
	// Strap pulses, count chosen by caller
	task automatic factory_pulses(input int n);
		repeat (n) begin
			fact <= 1'b0;
			repeat (4) @(posedge clk);
			fact <= 1'b1;
			repeat (4) @(posedge clk);
		end
	endtask
	// Mid-bit sampling; a bad stop bit is not flagged
	always begin
		logic [7:0] b;
		@(negedge devTx);
		repeat (bitCyc / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bitCyc) @(posedge clk);
			b[i] = devTx;
		end
		repeat (bitCyc) @(posedge clk);
		rxQ.push_back(b);
	end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "pin_wake_cfg.svh"
module tb_top;
	logic        clk;
	logic        rst;
	logic [7:0]  addr;
	logic [31:0] wrData;
	logic        wrEn;
	logic        rdEn;
	logic [31:0] rdData;
	logic [9:0]  progPinIn;
	logic [9:0]  progPinOut;
	logic [9:0]  progPinOe;
	logic [9:0]  hostLvl;
	logic [9:0]  noise;
	logic [2:0]  sens;
	logic        asleep;
	logic        connReq;
	logic        hostTx;
	logic        cts;
	logic        conn;
	logic        fact;
	logic        rdSeen;
	logic        ok;
	logic [31:0] expQ[$];
	logic [31:0] mskQ[$];
	logic [7:0]  rxB[3];
	logic [7:0]  fwdTab[11] = '{2, 4, 8, 16, 32, 64, 96, 192, 255, 255, 255};
	int          seed = 32'h07f20c0e;
	int          cyc = 0;
	int          nMismatch = 0;
	int          totalChecks = 0;

	module_pin_wake_flow_ctrl #(.TICK_CYCLES(100)) u_dut (.clk(clk),
		.rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
		.rdData(rdData), .progPinIn(progPinIn), .progPinOut(progPinOut),
		.progPinOe(progPinOe), .wakeSenseIn({sens, hostTx}),
		.asleep(asleep), .connReq(connReq));
	host_mcu_model u_host (.clk(clk), .devTx(progPinOut[0]),
		.hostTx(hostTx), .cts(cts), .conn(conn), .fact(fact));

	// Undriven pins float to a changing pattern, not a held value
	assign hostLvl = {fact, noise[8:6], conn, noise[4:3], cts, hostTx,
		noise[0]};
	assign progPinIn = (progPinOe & progPinOut) | (~progPinOe & hostLvl);
	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(posedge clk) noise <= 10'($random(seed));

	// Read answers stand only in the cycle after the strobe
	always @(posedge clk) begin
		rdSeen <= rdEn;
		if (rdSeen === 1'b1)
			chk(rdData & mskQ.pop_front(), expQ.pop_front());
	end
	// Cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			nMismatch++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
		// One idle edge, so a following call never rewrites the strobe
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		addr <= a;
		rdEn <= 1'b1;
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge clk);
		rdEn <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_sleep(input logic lvl, input int lim);
		for (int n = 0; n < lim && asleep !== lvl; n++)
			@(posedge clk);
		chk(asleep, lvl);
	endtask
	task automatic wait_rx(input int cnt);
		for (int n = 0; n < 5000 && u_host.rxQ.size() < cnt; n++)
			@(posedge clk);
	endtask
	// Status word: bytes released for forwarding, bytes buffered
	function automatic logic [31:0] st(input int av, input int cn);
		return (32'(av) << 17) | (32'(cn) << 6);
	endfunction
	task automatic tend(input string s);
		$display("test %s done, %0d checks", s, totalChecks);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wrData = 32'h0;
		wrEn = 1'b0;
		rdEn = 1'b0;
		sens = 3'h7;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		// Power-up values, one unmapped address
		chk({progPinOe, progPinOut[3]}, 11'h0f3);
		rd(`OFS_WAKE, 32'h1, 32'h7);
		rd(`OFS_WAKET, 32'h0a, 32'hffff);
		rd(`OFS_FSIZE, 32'h10, 32'hff);
		rd(`OFS_UART, 32'h0, 32'h7);
		rd(`OFS_BAUD, 32'h3, 32'hf);
		rd(`OFS_IOMASK, 32'h78, 32'h3ff);
		rd(`OFS_PRINT, 32'h0, 32'hff);
		rd(`OFS_STATUS, 32'h18, 32'h18);
		rd(8'hfc, 32'h0, 32'hffffffff);
		tend("defaults");
		// Direction mask, reserved bits, plain output pin
		// Pin 9 stays an input so the strap count is not disturbed
		wr(`OFS_IOMASK, 32'h1ff);
		rd(`OFS_IOMASK, 32'h07f, 32'h3ff);
		wr(`OFS_IOMASK, 32'h0);
		repeat (3) @(posedge clk);
		chk(progPinOe, 10'h001);
		wr(`OFS_IOMASK, 32'h010);
		wr(`OFS_GPOUT, 32'h010);
		repeat (3) @(posedge clk);
		chk({progPinOe[4], progPinOut[4]}, 2'b11);
		tend("mask");
		// Baud codes 0 to 10 each reload the forwarding count
		for (int i = 0; i < 11; i++) begin
			wr(`OFS_BAUD, i);
			rd(`OFS_FSIZE, fwdTab[i], 32'hff);
		end
		wr(`OFS_FSIZE, 32'h3);
		rd(`OFS_FSIZE, 32'h3, 32'hff);
		tend("baud");
		// Count release at the exact boundary, then in order
		for (int i = 0; i < 3; i++) begin
			rxB[i] = 8'($random(seed));
			u_host.send(rxB[i]);
			repeat (4) @(posedge clk);
			rd(`OFS_STATUS, (i == 2) ? st(3, 3) : st(0, i + 1),
				32'h0fffffc0);
		end
		for (int i = 0; i < 3; i++)
			rd(`OFS_RXDATA, rxB[i], 32'hff);
		wr(`OFS_FSIZE, 32'h0);
		u_host.send(8'h5a);
		repeat (4) @(posedge clk);
		rd(`OFS_STATUS, st(1, 1), 32'h0fffffc0);
		rd(`OFS_RXDATA, 32'h5a, 32'hff);
		// Terminator byte releases before the count is reached
		wr(`OFS_FSIZE, 32'hff);
		wr(`OFS_MATCH, 32'h10d);
		u_host.send(8'h41);
		repeat (4) @(posedge clk);
		rd(`OFS_STATUS, st(0, 1), 32'h0fffffc0);
		u_host.send(8'h0d);
		repeat (4) @(posedge clk);
		rd(`OFS_STATUS, st(2, 2), 32'h0fffffc0);
		rd(`OFS_RXDATA, 32'h41, 32'hff);
		rd(`OFS_RXDATA, 32'h0d, 32'hff);
		tend("rx");
		// RTS follows readiness; CTS high holds the transmitter
		wr(`OFS_UART, 32'h1);
		repeat (3) @(posedge clk);
		chk({progPinOe[3], progPinOut[3]}, 2'b11);
		wr(`OFS_NETCTL, 32'h1);
		repeat (4) @(posedge clk);
		chk({progPinOe[3], progPinOut[3]}, 2'b10);
		u_host.cts <= 1'b1;
		repeat (4) @(posedge clk);
		wr(`OFS_TXDATA, 32'ha5);
		ok = 1'b1;
		repeat (300) begin
			@(posedge clk);
			ok = ok & progPinOut[0];
		end
		chk(ok, 1'b1);
		u_host.cts <= 1'b0;
		wait_rx(1);
		chk(u_host.rxQ.pop_front(), 8'ha5);
		tend("flow");
		// Alternate functions override the mask roles
		wr(`OFS_IOFUNC, 32'h7);
		repeat (4) @(posedge clk);
		chk({progPinOut[4], progPinOe[5]}, 2'b00);
		wr(`OFS_NETCTL, 32'h7);
		repeat (4) @(posedge clk);
		chk({progPinOe[4], progPinOut[4]}, 2'b11);
		wr(`OFS_OPENSTR, 32'h4241);
		wr(`OFS_NETCTL, 32'hf);
		repeat (4) @(posedge clk);
		chk({progPinOe[6], progPinOut[6]}, 2'b11);
		wait_rx(2);
		chk(u_host.rxQ.pop_front(), 8'h41);
		chk(u_host.rxQ.pop_front(), 8'h42);
		u_host.conn <= 1'b1;
		repeat (5) @(posedge clk);
		chk(connReq, 1'b1);
		u_host.conn <= 1'b0;
		repeat (5) @(posedge clk);
		chk(connReq, 1'b0);
		wr(`OFS_NETCTL, 32'h1);
		repeat (4) @(posedge clk);
		chk(progPinOut[6], 1'b0);
		tend("altfunc");
		// Sleep countdown, disabled trigger, sensor and serial wake
		wr(`OFS_WAKET, 32'h0);
		wr(`OFS_WAKE, 32'h0);
		wr(`OFS_NETCTL, 32'h11);
		wr(`OFS_SLEEP, 32'h1);
		repeat (300) @(posedge clk);
		chk(asleep, 1'b0);
		wr(`OFS_NETCTL, 32'h1);
		wait_sleep(1'b1, 300);
		wr(`OFS_SLEEP, 32'h0);
		sens <= 3'h0;
		repeat (50) @(posedge clk);
		chk(asleep, 1'b1);
		wr(`OFS_WAKE, 32'h2);
		wait_sleep(1'b0, 20);
		sens <= 3'h7;
		wr(`OFS_WAKE, 32'h1);
		wr(`OFS_SLEEP, 32'h1);
		wait_sleep(1'b1, 300);
		wr(`OFS_SLEEP, 32'h0);
		u_host.send(8'h55);
		chk(asleep, 1'b0);
		// Timed wake after two ticks
		wr(`OFS_WAKET, 32'h2);
		wr(`OFS_SLEEP, 32'h1);
		wait_sleep(1'b1, 300);
		wr(`OFS_SLEEP, 32'h0);
		wait_sleep(1'b0, 400);
		tend("sleep");
		// Strap pulses restore factory values
		wr(`OFS_IOMASK, 32'h0);
		u_host.factory_pulses(2);
		repeat (5) @(posedge clk);
		rd(`OFS_IOMASK, 32'h0, 32'h3ff);
		u_host.factory_pulses(1);
		repeat (5) @(posedge clk);
		rd(`OFS_IOMASK, 32'h78, 32'h3ff);
		rd(`OFS_UART, 32'h0, 32'h7);
		repeat (3) @(posedge clk);
		tend("factory");
		final_report();
	end
endmodule
